// File: hdl/prbl_byte_lane.sv
`timescale 1ns/100ps
module prbl_byte_lane (
  // clock and reset
  input  logic       clk,
  input  logic       nrst,
  input  logic       ce,
  // cpu access
  input  logic       acc_valid,
  input  logic [1:0] acc_target,
  // settings
  input  logic [1:0] ext_mode,
  input  logic [1:0] usb_mode,
  input  logic [1:0] bus_w,
  // result
  output logic       out_valid,
  output logic [1:0] out_target,
  output logic [1:0] lane_en,
  output logic [1:0] ext_count
);

  typedef struct packed {
    logic       vld;
    logic [1:0] tgt;
    logic [1:0] lane;
    logic [1:0] cnt;
  } prbl_lane_state_type;

  prbl_lane_state_type st_r;
  prbl_lane_state_type st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.vld = acc_valid;
    st_nxt.tgt = acc_target;
    st_nxt.cnt = 2'h0;
    case (acc_target)
      prbl_pkg::TGT_EXT_MEM: begin
        st_nxt.lane = prbl_pkg::lane_sel(ext_mode);
        st_nxt.cnt  = ((bus_w == prbl_pkg::WIDTH_8) && (st_nxt.lane == 2'h3)) ? 2'h2 : 2'h1;
      end
      prbl_pkg::TGT_EXT_REG: st_nxt.lane = prbl_pkg::lane_sel(ext_mode);
      prbl_pkg::TGT_USB_REG: st_nxt.lane = prbl_pkg::lane_sel(usb_mode);
      default:               st_nxt.lane = 2'h3;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{vld: 1'b0, tgt: prbl_pkg::TGT_OTHER, lane: 2'h3, cnt: 2'h0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign out_valid  = st_r.vld;
  assign out_target = st_r.tgt;
  assign lane_en    = st_r.lane;
  assign ext_count  = st_r.cnt;

  a_word_two_bytes: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_target == prbl_pkg::TGT_EXT_MEM && ext_mode == prbl_pkg::MODE_WORD
    && bus_w == prbl_pkg::WIDTH_8 |=> ext_count == 2'h2 && lane_en == 2'h3)
    else $error("word on 8-bit bus is not two accesses");
  a_high_lanes: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_target == prbl_pkg::TGT_EXT_MEM && ext_mode == prbl_pkg::MODE_HIGH
    |=> ext_count == 2'h1 && lane_en == 2'h2)
    else $error("high byte access wrong");
  a_low_lanes: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_target == prbl_pkg::TGT_EXT_MEM && ext_mode == prbl_pkg::MODE_LOW
    |=> ext_count == 2'h1 && lane_en == 2'h1)
    else $error("low byte access wrong");
  a_usb_own_mode: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_target == prbl_pkg::TGT_USB_REG && usb_mode == prbl_pkg::MODE_WORD
    |=> lane_en == 2'h3 && ext_count == 2'h0)
    else $error("usb access not whole word");
  a_other_word: assert property (@(posedge clk) disable iff (!nrst)
    ce && acc_target == prbl_pkg::TGT_OTHER |=> lane_en == 2'h3 && ext_count == 2'h0)
    else $error("unrelated access masked");

endmodule

// File: hdl/prbl_pkg.sv
package prbl_pkg;

  // ****************************************
  // clock
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;

  // ****************************************
  // register indices, byte address = 4 * index
  // ****************************************
  localparam logic [15:0] IDX_DURATION  = 16'h1C04;
  localparam logic [15:0] IDX_GROUP_RST = 16'h1C05;
  localparam logic [15:0] IDX_EXT_LANE  = 16'h1C33;
  localparam logic [15:0] IDX_USB_LANE  = 16'h1C40;
  localparam logic [15:0] IDX_BUS_WIDTH = 16'h1C41;

  localparam logic [17:0] ADDR_DURATION  = {IDX_DURATION, 2'h0};
  localparam logic [17:0] ADDR_GROUP_RST = {IDX_GROUP_RST, 2'h0};
  localparam logic [17:0] ADDR_EXT_LANE  = {IDX_EXT_LANE, 2'h0};
  localparam logic [17:0] ADDR_USB_LANE  = {IDX_USB_LANE, 2'h0};
  localparam logic [17:0] ADDR_BUS_WIDTH = {IDX_BUS_WIDTH, 2'h0};

  // ****************************************
  // group reset field
  // ****************************************
  localparam logic [7:0]  GROUP_MASK     = 8'hBF;
  localparam logic [15:0] DURATION_RST   = 16'h0000;
  localparam logic [7:0]  GROUP_RST_N_RST = 8'hFF;

  // ****************************************
  // byte lane modes and widths
  // ****************************************
  localparam logic [1:0] MODE_WORD     = 2'h0;
  localparam logic [1:0] MODE_HIGH     = 2'h1;
  localparam logic [1:0] MODE_LOW      = 2'h2;
  localparam logic [1:0] LANE_MODE_RST = 2'h0;
  localparam logic [1:0] WIDTH_8       = 2'h0;
  localparam logic [1:0] WIDTH_16      = 2'h1;
  localparam logic [1:0] BUS_WIDTH_RST = 2'h1;

  localparam logic [1:0] TGT_OTHER   = 2'h0;
  localparam logic [1:0] TGT_EXT_MEM = 2'h1;
  localparam logic [1:0] TGT_EXT_REG = 2'h2;
  localparam logic [1:0] TGT_USB_REG = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // lane enables {high, low}; reserved code acts as word
  function automatic logic [1:0] lane_sel(input logic [1:0] mode);
    case (mode)
      MODE_HIGH: lane_sel = 2'h2;
      MODE_LOW:  lane_sel = 2'h1;
      default:   lane_sel = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? dat[15:8] : old[15:8], strb[0] ? dat[7:0] : old[7:0]};
  endfunction

endpackage

// File: hdl/prbl_reset_counter.sv
`timescale 1ns/100ps
module prbl_reset_counter (
  // clock and reset
  input  logic        clk,
  input  logic        nrst,
  input  logic        ce,
  // control
  input  logic [7:0]  trig,
  input  logic [15:0] dur,
  // state
  output logic [7:0]  act,
  output logic [7:0]  rst_n
);

  typedef struct packed {
    logic [7:0]  act;
    logic [15:0] cnt;
    logic [7:0]  rst_n;
  } prbl_cnt_state_type;

  prbl_cnt_state_type st_r;
  prbl_cnt_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (|trig) begin
      st_nxt.act = st_r.act | trig;
      st_nxt.cnt = dur;
    end else if (|st_r.act) begin
      if (st_r.cnt <= 16'h0001) begin
        st_nxt.act = 8'h00;
      end
      st_nxt.cnt = (st_r.cnt == 16'h0000) ? 16'h0000 : 16'(st_r.cnt - 16'h0001);
    end
    st_nxt.rst_n = ~st_nxt.act;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{act: 8'h00, cnt: prbl_pkg::DURATION_RST, rst_n: prbl_pkg::GROUP_RST_N_RST};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign act   = st_r.act;
  assign rst_n = st_r.rst_n;

  a_trig_loads: assert property (@(posedge clk) disable iff (!nrst)
    ce && (|trig) |=> ((act & $past(trig)) == $past(trig)) && (st_r.cnt == $past(dur)))
    else $error("trigger did not start reset");
  a_zero_idle: assert property (@(posedge clk) disable iff (!nrst)
    ce && (trig == 8'h00) && (act == 8'h00) |=> act == 8'h00)
    else $error("reset started without a trigger");
  a_hold_count: assert property (@(posedge clk) disable iff (!nrst)
    ce && (trig == 8'h00) && (st_r.cnt > 16'h0001) |=> act == $past(act))
    else $error("reset released early");
  a_end_clears: assert property (@(posedge clk) disable iff (!nrst)
    ce && (trig == 8'h00) && (st_r.cnt <= 16'h0001) |=> act == 8'h00)
    else $error("reset not released at count end");

endmodule

// File: hdl/prbl_top.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module prbl_top (
  // clock and reset
  input  logic        clk,
  input  logic        nrst,
  input  logic        ce,
  // axi4-lite write address
  input  logic [17:0] s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  // axi4-lite write data
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  // axi4-lite read address
  input  logic [17:0] s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  // cpu access classification
  input  logic        acc_valid,
  input  logic [1:0]  acc_target,
  output logic        acc_out_valid,
  output logic [1:0]  acc_out_target,
  output logic [1:0]  acc_lane_en,
  output logic [1:0]  acc_ext_count,
  // peripheral group resets
  output logic        grp4_rst_n,
  output logic        grp3_rst_n,
  output logic        dma_rst_n,
  output logic        usb_rst_n,
  output logic        analog_rst_n,
  output logic        grp1_rst_n,
  output logic        i2c_rst_n
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        awrdy;
    logic        aw_got;
    logic [17:0] aw_addr;
    logic        wrdy;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvld;
    logic [1:0]  bresp;
    logic        ardy;
    logic        rvld;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] dur;
    logic [1:0]  ext_mode;
    logic [1:0]  usb_mode;
    logic [1:0]  bus_w;
    logic [7:0]  trig;
  } prbl_top_state_type;

  prbl_top_state_type st_r;
  prbl_top_state_type st_nxt;

  logic [7:0]  grp_act;
  logic [7:0]  grp_rst_n;
  logic [15:0] wr_val;
  logic [17:0] wr_addr;
  logic [17:0] rd_addr;
  logic        wr_go;

  // ****************************************
  // register bus
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    wr_val      = 16'h0000;
    st_nxt.trig = 8'h00;
    wr_addr     = {st_r.aw_addr[17:2], 2'h0};
    rd_addr     = {s_axi_araddr[17:2], 2'h0};
    wr_go       = st_r.aw_got && st_r.w_got && !st_r.bvld;

    if (s_axi_awvalid && st_r.awrdy) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awrdy   = 1'b0;
    end

    if (s_axi_wvalid && st_r.wrdy) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.wrdy   = 1'b0;
    end

    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvld   = 1'b1;
      st_nxt.bresp  = prbl_pkg::RESP_OKAY;
      case (wr_addr)
        prbl_pkg::ADDR_DURATION: begin
          st_nxt.dur = prbl_pkg::merge16(st_r.dur, st_r.w_data[15:0], st_r.w_strb[1:0]);
        end
        prbl_pkg::ADDR_GROUP_RST: begin
          wr_val      = prbl_pkg::merge16(16'h0000, st_r.w_data[15:0], st_r.w_strb[1:0]);
          st_nxt.trig = wr_val[7:0] & prbl_pkg::GROUP_MASK;
        end
        prbl_pkg::ADDR_EXT_LANE: begin
          wr_val = prbl_pkg::merge16({14'h0000, st_r.ext_mode},
                                     st_r.w_data[15:0], st_r.w_strb[1:0]);
          st_nxt.ext_mode = wr_val[1:0];
        end
        prbl_pkg::ADDR_USB_LANE: begin
          wr_val = prbl_pkg::merge16({14'h0000, st_r.usb_mode},
                                     st_r.w_data[15:0], st_r.w_strb[1:0]);
          st_nxt.usb_mode = wr_val[1:0];
        end
        prbl_pkg::ADDR_BUS_WIDTH: begin
          wr_val = prbl_pkg::merge16({14'h0000, st_r.bus_w},
                                     st_r.w_data[15:0], st_r.w_strb[1:0]);
          st_nxt.bus_w = wr_val[1:0];
        end
        default: begin
          st_nxt.bresp = prbl_pkg::RESP_DECERR;
        end
      endcase
    end

    if (st_r.bvld && s_axi_bready) begin
      st_nxt.bvld  = 1'b0;
      st_nxt.awrdy = 1'b1;
      st_nxt.wrdy  = 1'b1;
    end

    if (s_axi_arvalid && st_r.ardy) begin
      st_nxt.ardy  = 1'b0;
      st_nxt.rvld  = 1'b1;
      st_nxt.rresp = prbl_pkg::RESP_OKAY;
      case (rd_addr)
        prbl_pkg::ADDR_DURATION: begin
          st_nxt.rdata = {16'h0000, st_r.dur};
        end
        prbl_pkg::ADDR_GROUP_RST: begin
          st_nxt.rdata = {24'h000000, grp_act & prbl_pkg::GROUP_MASK};
        end
        prbl_pkg::ADDR_EXT_LANE: begin
          st_nxt.rdata = {30'h00000000, st_r.ext_mode};
        end
        prbl_pkg::ADDR_USB_LANE: begin
          st_nxt.rdata = {30'h00000000, st_r.usb_mode};
        end
        prbl_pkg::ADDR_BUS_WIDTH: begin
          st_nxt.rdata = {30'h00000000, st_r.bus_w};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = prbl_pkg::RESP_DECERR;
        end
      endcase
    end

    if (st_r.rvld && s_axi_rready) begin
      st_nxt.rvld = 1'b0;
      st_nxt.ardy = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{awrdy: 1'b1, aw_got: 1'b0, aw_addr: 18'h00000,
                wrdy: 1'b1, w_got: 1'b0, w_data: 32'h00000000, w_strb: 4'h0,
                bvld: 1'b0, bresp: prbl_pkg::RESP_OKAY,
                ardy: 1'b1, rvld: 1'b0, rdata: 32'h00000000,
                rresp: prbl_pkg::RESP_OKAY,
                dur: prbl_pkg::DURATION_RST,
                ext_mode: prbl_pkg::LANE_MODE_RST,
                usb_mode: prbl_pkg::LANE_MODE_RST,
                bus_w: prbl_pkg::BUS_WIDTH_RST,
                trig: 8'h00};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // group reset timing
  // ****************************************
  prbl_reset_counter u_cnt (
    .clk   (clk),
    .nrst  (nrst),
    .ce    (ce),
    .trig  (st_r.trig),
    .dur   (st_r.dur),
    .act   (grp_act),
    .rst_n (grp_rst_n)
  );

  // ****************************************
  // byte lane selection
  // ****************************************
  prbl_byte_lane u_lane (
    .clk        (clk),
    .nrst       (nrst),
    .ce         (ce),
    .acc_valid  (acc_valid),
    .acc_target (acc_target),
    .ext_mode   (st_r.ext_mode),
    .usb_mode   (st_r.usb_mode),
    .bus_w      (st_r.bus_w),
    .out_valid  (acc_out_valid),
    .out_target (acc_out_target),
    .lane_en    (acc_lane_en),
    .ext_count  (acc_ext_count)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready = st_r.awrdy;
  assign s_axi_wready  = st_r.wrdy;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_bvalid  = st_r.bvld;
  assign s_axi_arready = st_r.ardy;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rvalid  = st_r.rvld;

  assign grp4_rst_n   = grp_rst_n[7];
  assign grp3_rst_n   = grp_rst_n[5];
  assign dma_rst_n    = grp_rst_n[4];
  assign usb_rst_n    = grp_rst_n[3];
  assign analog_rst_n = grp_rst_n[2];
  assign grp1_rst_n   = grp_rst_n[1];
  assign i2c_rst_n    = grp_rst_n[0];

  // ****************************************
  // checks
  // ****************************************
  a_write_trig: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_GROUP_RST && st_r.w_strb[0]
    |=> st_r.trig == ($past(st_r.w_data[7:0]) & prbl_pkg::GROUP_MASK))
    else $error("group write did not trigger");
  a_trig_to_pin: assert property (@(posedge clk) disable iff (!nrst)
    ce && st_r.trig[3] |=> !usb_rst_n)
    else $error("usb reset not asserted after trigger");
  a_read_status: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_arvalid && st_r.ardy && rd_addr == prbl_pkg::ADDR_GROUP_RST
    |=> s_axi_rvalid && s_axi_rdata[7:0] == ($past(grp_act) & prbl_pkg::GROUP_MASK))
    else $error("status read wrong");
  a_pins_match: assert property (@(posedge clk) disable iff (!nrst)
    {grp4_rst_n, grp3_rst_n, dma_rst_n, analog_rst_n, grp1_rst_n, i2c_rst_n}
    == ~{grp_act[7], grp_act[5], grp_act[4], grp_act[2], grp_act[1], grp_act[0]})
    else $error("group reset pin mismatch");
  a_resp_follows: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_axi_bvalid) |-> $past(st_r.aw_got && st_r.w_got))
    else $error("write response without address and data");
  a_unmapped_err: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_arvalid && st_r.ardy && rd_addr != prbl_pkg::ADDR_DURATION
    && rd_addr != prbl_pkg::ADDR_GROUP_RST && rd_addr != prbl_pkg::ADDR_EXT_LANE
    && rd_addr != prbl_pkg::ADDR_USB_LANE && rd_addr != prbl_pkg::ADDR_BUS_WIDTH
    |=> s_axi_rresp == prbl_pkg::RESP_DECERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  a_mode_store: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_EXT_LANE && st_r.w_strb[0]
    |=> st_r.ext_mode == $past(st_r.w_data[1:0]))
    else $error("byte mode not stored");
  a_zero_no_trig: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_GROUP_RST && st_r.w_data[7:0] == 8'h00
    |=> st_r.trig == 8'h00)
    else $error("zero write started a reset");
  a_trig_all_pins: assert property (@(posedge clk) disable iff (!nrst)
    ce && (|st_r.trig) |=> (grp_rst_n & $past(st_r.trig)) == 8'h00)
    else $error("triggered group not in reset");
  a_usb_pin: assert property (@(posedge clk) disable iff (!nrst)
    usb_rst_n == !grp_act[3])
    else $error("usb reset pin mismatch");
  a_grp_rd_mask: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_arvalid && st_r.ardy && rd_addr == prbl_pkg::ADDR_GROUP_RST
    |=> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[6])
    else $error("reserved status bits set");
  a_dur_store: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_DURATION && (&st_r.w_strb[1:0])
    |=> st_r.dur == $past(st_r.w_data[15:0]))
    else $error("duration not stored");
  a_usb_mode_store: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_USB_LANE && st_r.w_strb[0]
    |=> st_r.usb_mode == $past(st_r.w_data[1:0]))
    else $error("usb byte mode not stored");
  a_ext_mode_read: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_arvalid && st_r.ardy && rd_addr == prbl_pkg::ADDR_EXT_LANE
    |=> s_axi_rdata == {30'h00000000, $past(st_r.ext_mode)})
    else $error("byte mode read wrong");
  a_grp_wr_only: assert property (@(posedge clk) disable iff (!nrst)
    ce && wr_go && wr_addr == prbl_pkg::ADDR_GROUP_RST
    |=> $stable(st_r.dur) && $stable(st_r.ext_mode) && $stable(st_r.usb_mode))
    else $error("group write changed other registers");

  // ****************************************
  // bus protocol checks
  // ****************************************
  a_b_done: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not released");
  a_r_done: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_w_refused: assert property (@(posedge clk) disable iff (!nrst)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_ar_refused: assert property (@(posedge clk) disable iff (!nrst)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");

endmodule

// File: tb/prbl_periph_model.sv
`timescale 1ns/100ps
module prbl_periph_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // reset lines, i2c at index 0, group four at index 6
  input  wire logic [6:0]  rst_n,
  // observed reset pulses
  output logic      [15:0] last_len [7],
  output logic      [7:0]  n_pulse  [7]
);
  logic [15:0] run_len [7];

  // ****************************************
  // peripherals count cycles held in reset
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    for (int i = 0; i < 7; i++) begin
      if (!nrst) begin
        run_len[i]  <= 16'h0000;
        last_len[i] <= 16'h0000;
        n_pulse[i]  <= 8'h00;
      end else if (!rst_n[i]) begin
        run_len[i] <= run_len[i] + 16'h0001;
      end else if (run_len[i] != 16'h0000) begin
        last_len[i] <= run_len[i];
        n_pulse[i]  <= n_pulse[i] + 8'h01;
        run_len[i]  <= 16'h0000;
      end
    end
  end
endmodule

// File: tb/tb_periph_reset_and_byte_lane_ctrl.sv
`timescale 1ns/100ps
module tb_periph_reset_and_byte_lane_ctrl;
  localparam logic [15:0] DUR = 16'h0010;
  localparam logic [17:0] UNMAPPED = 18'h00100;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [17:0] awaddr = 18'h00000;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [17:0] araddr = 18'h00000;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic        acc_valid = 1'b0;
  logic [1:0]  acc_target = 2'h0;
  logic        out_valid;
  logic [1:0]  out_target;
  logic [1:0]  lane_en;
  logic [1:0]  ext_count;
  logic [6:0]  lines;
  logic [15:0] last_len [7];
  logic [7:0]  n_pulse  [7];
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          bitpos [7] = '{0, 1, 2, 3, 4, 5, 7};

  always #50 clk = ~clk;

  prbl_top uut (
    .clk(clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .acc_valid(acc_valid), .acc_target(acc_target), .acc_out_valid(out_valid),
    .acc_out_target(out_target), .acc_lane_en(lane_en), .acc_ext_count(ext_count),
    .grp4_rst_n(lines[6]), .grp3_rst_n(lines[5]), .dma_rst_n(lines[4]),
    .usb_rst_n(lines[3]), .analog_rst_n(lines[2]), .grp1_rst_n(lines[1]),
    .i2c_rst_n(lines[0])
  );

  prbl_periph_model periph (
    .clk(clk), .nrst(nrst), .rst_n(lines), .last_len(last_len), .n_pulse(n_pulse)
  );

  // ****************************************
  // compare, report, bus tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    n_mismatch++;
    $display("CHECK FAILED %s expected answer seen none", what);
    test_done();
  endtask

  task automatic axi_write(input logic [17:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (!w_ok && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      if (bvalid) begin
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge clk);
        return;
      end
    end
    timeout("bvalid");
  endtask

  task automatic axi_read(input logic [17:0] a, input logic [15:0] ed, input logic [1:0] er);
    logic ar_ok;
    ar_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (!ar_ok && arready) begin
        arvalid <= 1'b0;
        ar_ok = 1'b1;
      end
      if (rvalid) begin
        rready <= 1'b0;
        chk("rdata", {16'h0000, ed}, rdata);
        chk("rresp", 32'(er), 32'(rresp));
        @(posedge clk);
        return;
      end
    end
    timeout("rvalid");
  endtask

  task automatic wait_quiet;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      if (lines === 7'h7F) begin
        @(posedge clk);
        return;
      end
    end
    timeout("reset release");
  endtask

  function automatic logic [1:0] exp_lane(input int m);
    if (m == 1) begin
      return 2'h2;
    end
    if (m == 2) begin
      return 2'h1;
    end
    return 2'h3;
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axi_read(prbl_pkg::ADDR_DURATION, 16'h0000, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_GROUP_RST, 16'h0000, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_EXT_LANE, 16'h0000, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_USB_LANE, 16'h0000, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_BUS_WIDTH, 16'h0001, prbl_pkg::RESP_OKAY);
    axi_read(UNMAPPED, 16'h0000, prbl_pkg::RESP_DECERR);
    axi_write(UNMAPPED, 16'h00FF, prbl_pkg::RESP_DECERR);
    chk("lines idle", 32'h0000007F, 32'(lines));
    axi_write(prbl_pkg::ADDR_DURATION, DUR, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_DURATION, DUR, prbl_pkg::RESP_OKAY);
    // each group bit drives exactly its own line
    for (int i = 0; i < 7; i++) begin
      axi_write(prbl_pkg::ADDR_GROUP_RST, 16'h0001 << bitpos[i], prbl_pkg::RESP_OKAY);
      axi_read(prbl_pkg::ADDR_GROUP_RST, 16'h0001 << bitpos[i], prbl_pkg::RESP_OKAY);
      wait_quiet();
      axi_read(prbl_pkg::ADDR_GROUP_RST, 16'h0000, prbl_pkg::RESP_OKAY);
      chk("pulse length", 32'(DUR), 32'(last_len[i]));
      for (int j = 0; j < 7; j++) begin
        chk("pulse count", 32'(j <= i), 32'(n_pulse[j]));
      end
    end
    // zero written in mid-reset and while idle
    axi_write(prbl_pkg::ADDR_GROUP_RST, 16'h0001, prbl_pkg::RESP_OKAY);
    axi_write(prbl_pkg::ADDR_GROUP_RST, 16'h0000, prbl_pkg::RESP_OKAY);
    axi_read(prbl_pkg::ADDR_GROUP_RST, 16'h0001, prbl_pkg::RESP_OKAY);
    wait_quiet();
    chk("pulse length", 32'(DUR), 32'(last_len[0]));
    axi_write(prbl_pkg::ADDR_GROUP_RST, 16'h0000, prbl_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    chk("lines after zero", 32'h0000007F, 32'(lines));
    chk("pulse count", 32'h00000002, 32'(n_pulse[0]));
    // enable low freezes the count
    axi_write(prbl_pkg::ADDR_GROUP_RST, 16'h0001, prbl_pkg::RESP_OKAY);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    wait_quiet();
    chk("frozen pulse length", 32'(DUR) + 32'h00000005, 32'(last_len[0]));
    // byte lanes over every mode, bus width and target
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 2; w++) begin
        axi_write(prbl_pkg::ADDR_EXT_LANE, 16'(m), prbl_pkg::RESP_OKAY);
        axi_write(prbl_pkg::ADDR_USB_LANE, 16'(3 - m), prbl_pkg::RESP_OKAY);
        axi_write(prbl_pkg::ADDR_BUS_WIDTH, 16'(w), prbl_pkg::RESP_OKAY);
        axi_read(prbl_pkg::ADDR_EXT_LANE, 16'(m), prbl_pkg::RESP_OKAY);
        for (int t = 0; t < 4; t++) begin
          acc_valid <= 1'b1;
          acc_target <= 2'(t);
          @(posedge clk);
          acc_valid <= 1'b0;
          @(negedge clk);
          chk("out valid", 32'h00000001, 32'(out_valid));
          chk("out target", 32'(t), 32'(out_target));
          chk("lane", 32'(t == 0 ? 2'h3 : t == 3 ? exp_lane(3 - m) : exp_lane(m)),
              32'(lane_en));
          chk("ext count", t != 1 ? 0 : ((m == 0 || m == 3) && w == 0) ? 2 : 1,
              32'(ext_count));
          @(posedge clk);
        end
      end
    end
    @(negedge clk);
    chk("out idle", 32'h00000000, 32'(out_valid));
    test_done();
  end
endmodule
